/* hw/cpid_decoder.sv */
// Command pulse input decoder: mode decode, deviation counter, clear, run, alarm and APB registers.
// Assumes one 100 MHz clock, synchronous active-high reset and an APB master on the register port.
//
// Notes on behaviour
// R1 - A ten-valued mode, 0 to 9, selects pulse format and polarity.
// R2 - Mode 0: step pulses on first pair, direction high forward, low reverse.
// R3 - Mode 1: first pair pulses reverse, second pair pulses forward.
// R4 - Modes 2-4: quadrature A/B at x1, x2, x4; phase order gives direction.
// R5 - Modes 5-9 repeat 0-4 inverted; low direction means forward.
// R6 - Host keeps the same pulse timing in negative-logic modes.
// R7 - Active clear zeroes deviation, stops position loop, refuses command pulses.
// R8 - Clear must last 20 us; shorter assertions clear nothing.
// R9 - Drive stage on only with run active; otherwise only jog moves.
// R10 - Alarm-reset input clears the latched alarm.
// R11 - Host drops run before alarm reset and removes alarm cause first.
// R12 - Alarm output off at power-up, on after init, off on error.
// R13 - Positioning-done when deviation magnitude is below the in-position range.
// R14 - Inputs accept pulse rates up to 250 kpps; host stays below.
// R15 - All command and sequence inputs are synchronised and glitch filtered.
`default_nettype none

module cpid_decoder
    import cpid_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          clkEn,
    input  wire cpid_apb_req_t apbReq,
    output var  cpid_apb_rsp_t apbRsp,
    input  wire cpid_pins_t    pinsIn,
    input  wire logic          faultDetectIn,
    input  wire logic          fbFwdIn,
    input  wire logic          fbRevIn,
    output logic               stepFwdOut,
    output logic               stepRevOut,
    output logic               driveEnableOut,
    output logic               loopEnableOut,
    output logic               faultOut,
    output logic               positionDoneOut,
    output logic               irq
);

    typedef struct packed {
        logic [MODE_W-1:0]  mode;
        logic               jogFwd;
        logic               jogRev;
        logic [RANGE_W-1:0] range;
        logic               aPrev;
        logic               bPrev;
        logic [CNT_W-1:0]   clrCnt;
        logic               clearActive;
        logic [DEV_W-1:0]   dev;
        logic               stepFwd;
        logic               stepRev;
        logic               driveEn;
        logic               loopEn;
        logic               faultLatch;
        logic [CNT_W-1:0]   initCnt;
        logic               initDone;
        logic               faultOk;
        logic               posDone;
        logic [INT_W-1:0]   intStat;
        logic [INT_W-1:0]   intMask;
        logic [31:0]        prdata;
    } cpid_state_t;

    cpid_state_t st;
    cpid_state_t next_st;
    cpid_pins_t  filt;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic polarity(input logic lvl, input logic neg);
        return lvl ^ neg;
    endfunction

    function automatic logic [DEV_W-1:0] magnitude(input logic [DEV_W-1:0] v);
        return v[DEV_W-1] ? (~v + DEV_W'(1)) : v;
    endfunction

    function automatic logic regHit(input logic [7:0] addr);
        return addr inside {ADDR_CTRL, ADDR_RANGE, ADDR_DEV, ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK};
    endfunction

    // ---------------------------------------------------------------
    // Input conditioning
    // ---------------------------------------------------------------
    cpid_input_filter u_filter (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clkEn   (clkEn),
        .pinsIn  (pinsIn),
        .pinsOut (filt)
    ); // see R14 R15

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    logic              negMode;
    logic [MODE_W-1:0] baseMode;
    cpid_fmt_t         fmt;
    logic              aLvl;
    logic              bLvl;
    logic              cmdFwd;
    logic              cmdRev;
    logic              cmdOk;

    always_comb begin
        negMode  = (st.mode >= MODE_NEG_BASE) && (st.mode <= MODE_MAX); // see R5
        baseMode = negMode ? (st.mode - MODE_NEG_BASE) : st.mode;
        unique case (baseMode) // see R1
            4'h0:    fmt = CPID_FMT_STEP_DIR;
            4'h1:    fmt = CPID_FMT_REV_FWD;
            4'h2:    fmt = CPID_FMT_QUAD1;
            4'h3:    fmt = CPID_FMT_QUAD2;
            4'h4:    fmt = CPID_FMT_QUAD4;
            default: fmt = CPID_FMT_NONE;
        endcase
        aLvl   = polarity(filt.stepPulse, negMode); // see R5
        bLvl   = polarity(filt.dirPulse, negMode);
        cmdFwd = 1'b0;
        cmdRev = 1'b0;
        unique case (fmt)
            CPID_FMT_STEP_DIR: begin
                cmdFwd = !st.aPrev && aLvl && bLvl; // see R2
                cmdRev = !st.aPrev && aLvl && !bLvl;
            end
            CPID_FMT_REV_FWD: begin
                cmdRev = !st.aPrev && aLvl; // see R3
                cmdFwd = !st.bPrev && bLvl;
            end
            CPID_FMT_QUAD1: begin
                cmdFwd = !st.aPrev && aLvl && !bLvl; // see R4
                cmdRev = !st.aPrev && aLvl && bLvl;
            end
            CPID_FMT_QUAD2: begin
                cmdFwd = (st.aPrev != aLvl) && (st.bPrev == bLvl) && (aLvl ^ bLvl); // see R4
                cmdRev = (st.aPrev != aLvl) && (st.bPrev == bLvl) && !(aLvl ^ bLvl);
            end
            CPID_FMT_QUAD4: begin
                cmdFwd = ((st.aPrev != aLvl) ^ (st.bPrev != bLvl)) && (aLvl ^ st.bPrev); // see R4
                cmdRev = ((st.aPrev != aLvl) ^ (st.bPrev != bLvl)) && !(aLvl ^ st.bPrev);
            end
            CPID_FMT_NONE: begin
                cmdFwd = 1'b0;
                cmdRev = 1'b0;
            end
        endcase
        cmdOk = st.driveEn && !st.clearActive; // see R7
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic             apbWrite;
    logic [DEV_W-1:0] devStep;
    logic             overflow;
    logic             jogOk;
    logic [INT_W-1:0] intEvent;
    logic [INT_W-1:0] intClear;

    always_comb begin
        next_st  = st;
        apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
        jogOk    = !st.clearActive && !st.faultLatch && st.initDone;
        intClear = '0;

        // Power-up initialisation
        if (!st.initDone) begin
            next_st.initCnt  = st.initCnt + CNT_W'(1);
            next_st.initDone = (st.initCnt == INIT_COUNT - CNT_W'(1));
        end

        // Deviation clear qualification
        if (filt.devClear) begin
            next_st.clrCnt = (st.clrCnt == CLR_COUNT) ? st.clrCnt : st.clrCnt + CNT_W'(1); // see R8
        end else begin
            next_st.clrCnt = '0;
        end
        next_st.clearActive = filt.devClear && (next_st.clrCnt == CLR_COUNT); // see R8

        // Step outputs and deviation counter
        next_st.stepFwd = (cmdFwd && cmdOk) || (st.jogFwd && jogOk); // see R9
        next_st.stepRev = (cmdRev && cmdOk) || (st.jogRev && jogOk);
        next_st.jogFwd  = 1'b0;
        next_st.jogRev  = 1'b0;
        next_st.aPrev   = aLvl;
        next_st.bPrev   = bLvl;
        devStep = st.dev + DEV_W'(next_st.stepFwd) - DEV_W'(next_st.stepRev) - DEV_W'(fbFwdIn) + DEV_W'(fbRevIn);
        if (st.clearActive) begin
            next_st.dev = '0; // see R7
        end else begin
            next_st.dev = devStep;
        end
        overflow = !st.clearActive && (magnitude(devStep) >= DEV_LIMIT);

        // Run, loop and alarm
        next_st.driveEn = filt.run && !st.faultLatch && st.initDone; // see R9
        next_st.loopEn  = next_st.driveEn && !next_st.clearActive; // see R7
        if (faultDetectIn || overflow) begin
            next_st.faultLatch = 1'b1;
        end else if (filt.alarmReset) begin
            next_st.faultLatch = 1'b0; // see R10
        end
        next_st.faultOk = next_st.initDone && !next_st.faultLatch; // see R12
        next_st.posDone = magnitude(st.dev) < DEV_W'(st.range); // see R13

        // Interrupt events, set wins over clear
        intEvent                = '0;
        intEvent[INT_CLEAR]     = next_st.clearActive && !st.clearActive;
        intEvent[INT_FAULT]     = next_st.faultLatch && !st.faultLatch;
        intEvent[INT_FAULT_CLR] = !next_st.faultLatch && st.faultLatch;
        intEvent[INT_IN_POS]    = next_st.posDone && !st.posDone;

        // Register writes
        if (apbWrite) begin
            unique case (apbReq.paddr)
                ADDR_CTRL: begin
                    next_st.mode   = apbReq.pwdata[MODE_W-1:0]; // see R1
                    next_st.jogFwd = apbReq.pwdata[CTRL_JOG_FWD];
                    next_st.jogRev = apbReq.pwdata[CTRL_JOG_REV];
                end
                ADDR_RANGE:    next_st.range = apbReq.pwdata[RANGE_W-1:0];
                ADDR_INT_STAT: intClear = apbReq.pwdata[INT_W-1:0];
                ADDR_INT_MASK: next_st.intMask = apbReq.pwdata[INT_W-1:0];
                default:       next_st.range = st.range;
            endcase
        end
        next_st.intStat = (st.intStat & ~intClear) | intEvent;

        // Read data captured in the setup phase
        if (apbReq.psel && !apbReq.penable) begin
            unique case (apbReq.paddr)
                ADDR_CTRL:     next_st.prdata = 32'(st.mode);
                ADDR_RANGE:    next_st.prdata = 32'(st.range);
                ADDR_DEV:      next_st.prdata = {{(32 - DEV_W){st.dev[DEV_W-1]}}, st.dev};
                ADDR_STATUS:   next_st.prdata = 32'({st.clearActive, st.posDone, st.initDone, st.faultLatch,
                                                     st.loopEn, st.driveEn});
                ADDR_INT_STAT: next_st.prdata = 32'(st.intStat);
                ADDR_INT_MASK: next_st.prdata = 32'(st.intMask);
                default:       next_st.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st       <= '0;
            st.mode  <= MODE_RESET;
            st.range <= RANGE_RESET;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign stepFwdOut      = st.stepFwd;
    assign stepRevOut      = st.stepRev;
    assign driveEnableOut  = st.driveEn;
    assign loopEnableOut   = st.loopEn;
    assign faultOut        = st.faultOk;
    assign positionDoneOut = st.posDone;
    assign irq             = |(st.intStat & st.intMask);
    assign apbRsp.prdata   = st.prdata;
    assign apbRsp.pready   = 1'b1;
    assign apbRsp.pslverr  = apbReq.psel && apbReq.penable && !regHit(apbReq.paddr);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_mode0_fwd;
        @(posedge sys_clk) disable iff (reset)
        clkEn && (st.mode == 4'h0) && !st.aPrev && filt.stepPulse && filt.dirPulse && cmdOk |=> st.stepFwd;
    endproperty
    a_mode0_fwd: assert property (p_mode0_fwd) else $error("mode 0 step with direction high not forward"); // see R2

    property p_mode1_rev;
        @(posedge sys_clk) disable iff (reset)
        clkEn && (st.mode == 4'h1) && !st.aPrev && filt.stepPulse && cmdOk |=> st.stepRev;
    endproperty
    a_mode1_rev: assert property (p_mode1_rev) else $error("mode 1 first-pair pulse not reverse"); // see R3

    property p_quad4_count;
        @(posedge sys_clk) disable iff (reset)
        clkEn && (st.mode == 4'h4) && cmdOk && (aLvl != st.aPrev) && (bLvl == st.bPrev) |=> st.stepFwd ^ st.stepRev;
    endproperty
    a_quad4_count: assert property (p_quad4_count) else $error("x4 quadrature edge did not count"); // see R4

    property p_mode5_fwd;
        @(posedge sys_clk) disable iff (reset)
        clkEn && (st.mode == 4'h5) && !st.aPrev && !filt.stepPulse && !filt.dirPulse && cmdOk |=> st.stepFwd;
    endproperty
    a_mode5_fwd: assert property (p_mode5_fwd) else $error("negative mode low direction not forward"); // see R5

    property p_clear_holds;
        @(posedge sys_clk) disable iff (reset)
        clkEn && st.clearActive && filt.devClear |=> (st.dev == '0) && !st.stepFwd && !st.stepRev && !st.loopEn;
    endproperty
    a_clear_holds: assert property (p_clear_holds) else $error("clear active but counter or pulses not stopped"); // see R7

    property p_clear_min;
        @(posedge sys_clk) disable iff (reset)
        $rose(st.clearActive) |-> $past(filt.devClear) && (st.clrCnt == CLR_COUNT);
    endproperty
    a_clear_min: assert property (p_clear_min) else $error("deviation clear taken before 20 us"); // see R8

    property p_run_gate;
        @(posedge sys_clk) disable iff (reset)
        clkEn && !st.driveEn && !st.jogFwd && !st.jogRev |=> !st.stepFwd && !st.stepRev;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("motion without run or jog"); // see R9

    property p_alarm_reset;
        @(posedge sys_clk) disable iff (reset)
        clkEn && st.faultLatch && filt.alarmReset && !faultDetectIn && !overflow |=> !st.faultLatch;
    endproperty
    a_alarm_reset: assert property (p_alarm_reset) else $error("alarm reset did not clear alarm"); // see R10

    property p_alarm_out;
        @(posedge sys_clk) disable iff (reset)
        clkEn && (faultDetectIn || overflow) |=> !faultOut;
    endproperty
    a_alarm_out: assert property (p_alarm_out) else $error("alarm output on after fault"); // see R12

    property p_in_position;
        @(posedge sys_clk) disable iff (reset)
        clkEn |=> positionDoneOut == (magnitude($past(st.dev)) < DEV_W'($past(st.range)));
    endproperty
    a_in_position: assert property (p_in_position) else $error("positioning done disagrees with range"); // see R13

endmodule // cpid_decoder

`default_nettype wire

/* hw/cpid_input_filter.sv */
// Two-stage synchroniser and stability filter for the five command-side inputs.
// Assumes inputs may be asynchronous glitchy levels; output moves after FILT_CYCLES stable samples.
`default_nettype none

module cpid_input_filter
    import cpid_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clkEn,
    input  wire cpid_pins_t pinsIn,
    output var  cpid_pins_t pinsOut
);

    cpid_filt_state_t st;
    cpid_filt_state_t next_st;

    // ---------------------------------------------------------------
    // Filter
    // ---------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.sync1 = pinsIn;
        next_st.sync2 = st.sync1;
        for (int i = 0; i < NUM_IN; i++) begin
            if (st.sync2[i] == st.out[i]) begin
                next_st.cnt[i] = '0;
            end else if (st.cnt[i] == FILT_LAST) begin // see R15
                next_st.out[i] = st.sync2[i];
                next_st.cnt[i] = '0;
            end else begin
                next_st.cnt[i] = st.cnt[i] + FILT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign pinsOut = st.out;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_filter_stable;
        @(posedge sys_clk) disable iff (reset)
        !$past(reset) && (st.out[0] != $past(st.out[0])) |->
            ($past(st.cnt[0]) == FILT_LAST) && ($past(st.sync2[0]) == st.out[0]);
    endproperty
    a_filter_stable: assert property (p_filter_stable) else $error("filtered input moved before it was stable"); // see R15

endmodule // cpid_input_filter

`default_nettype wire

/* hw/cpid_pkg.sv */
// Shared constants, field layouts and carrier types of the command pulse input decoder.
// Assumes a single 100 MHz clock domain and an APB register port with 32-bit data.
`default_nettype none

package cpid_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLR_MIN_NS    = 20000;
    localparam int unsigned CLR_CYCLES    = (CLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INIT_NS       = 10000;
    localparam int unsigned INIT_CYCLES   = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILT_CYCLES   = 3;

    localparam int CNT_W  = 11;
    localparam int FILT_W = 2;
    localparam logic [CNT_W-1:0]  CLR_COUNT  = CNT_W'(CLR_CYCLES);
    localparam logic [CNT_W-1:0]  INIT_COUNT = CNT_W'(INIT_CYCLES);
    localparam logic [FILT_W-1:0] FILT_LAST  = FILT_W'(FILT_CYCLES - 1);

    // ---------------------------------------------------------------
    // Widths and limits
    // ---------------------------------------------------------------
    localparam int NUM_IN  = 5;
    localparam int DEV_W   = 24;
    localparam int RANGE_W = 16;
    localparam int MODE_W  = 4;
    localparam int INT_W   = 4;
    localparam logic [DEV_W-1:0]   DEV_LIMIT     = 24'h400000;
    localparam logic [RANGE_W-1:0] RANGE_RESET   = 16'h000A;
    localparam logic [MODE_W-1:0]  MODE_RESET    = 4'h0;
    localparam logic [MODE_W-1:0]  MODE_NEG_BASE = 4'h5;
    localparam logic [MODE_W-1:0]  MODE_MAX      = 4'h9;

    // ---------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_RANGE    = 8'h04;
    localparam logic [7:0] ADDR_DEV      = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    localparam int CTRL_JOG_FWD = 4;
    localparam int CTRL_JOG_REV = 5;
    localparam int INT_CLEAR     = 0;
    localparam int INT_FAULT     = 1;
    localparam int INT_FAULT_CLR = 2;
    localparam int INT_IN_POS    = 3;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CPID_FMT_STEP_DIR,
        CPID_FMT_REV_FWD,
        CPID_FMT_QUAD1,
        CPID_FMT_QUAD2,
        CPID_FMT_QUAD4,
        CPID_FMT_NONE
    } cpid_fmt_t;

    typedef struct packed {
        logic stepPulse;
        logic dirPulse;
        logic devClear;
        logic run;
        logic alarmReset;
    } cpid_pins_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cpid_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cpid_apb_rsp_t;

    typedef struct packed {
        logic [NUM_IN-1:0]             sync1;
        logic [NUM_IN-1:0]             sync2;
        logic [NUM_IN-1:0]             out;
        logic [NUM_IN-1:0][FILT_W-1:0] cnt;
    } cpid_filt_state_t;

endpackage

`default_nettype wire

/* verif/cpid_host_model.sv */
// Host controller model: one command step per go pulse, in the format of mode.
// Assumes go is raised for one cycle while busy is low.
`default_nettype none
module cpid_host_model
    import cpid_pkg::*;
#(
    parameter int HALF = 100
)
(
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic       fwd,
    input  wire logic [3:0] mode,
    output logic            pinA,
    output logic            pinB,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] w;
    logic       p;
    initial begin
        {pinA, pinB, busy} = 3'b000;
        forever begin
            @(posedge sys_clk);
            p = mode >= MODE_NEG_BASE;
            case (mode % 4'h5)
                4'h0: w = fwd ? 8'h74 : 8'h20;
                4'h1: w = fwd ? 8'h10 : 8'h20;
                default: w = fwd ? 8'hB4 : 8'h78;
            endcase
            if (go) begin
                busy <= 1'b1;
                // Four phases of HALF cycles: one step per 4 us
                for (int i = 3; i >= 0; i--) begin
                    {pinA, pinB} <= w[2*i+:2] ^ {p, p};
                    repeat (HALF) @(posedge sys_clk);
                end
                busy <= 1'b0;
            end else begin
                {pinA, pinB} <= {p, p};
            end
        end
    end
endmodule // cpid_host_model
`default_nettype wire

/* verif/tb.sv */
// Testbench: pulse modes, jog, clear, alarm, in-position and registers.
// Assumes the host model and the decoder package.
`default_nettype none
module tb
    import cpid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          sys_clk, reset, hostGo, hostFwd, hostA, hostB, busy, slvErr;
    logic          devClear, run, alarmReset, faultDetect, fbFwd, fbRev;
    logic          stepFwd, stepRev, driveEn, loopEn, faultOut, posDone, irq;
    logic [3:0]    hostMode;
    logic [31:0]   q;
    cpid_apb_req_t apbReq;
    cpid_apb_rsp_t apbRsp;
    int            errTotal, checked, fwdCnt, revCnt;

    cpid_host_model #(.HALF(100)) host (.sys_clk(sys_clk), .go(hostGo), .fwd(hostFwd), .mode(hostMode),
        .pinA(hostA), .pinB(hostB), .busy(busy));
    cpid_decoder dut (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .apbReq(apbReq), .apbRsp(apbRsp),
        .pinsIn({hostA, hostB, devClear, run, alarmReset}), .faultDetectIn(faultDetect), .fbFwdIn(fbFwd),
        .fbRevIn(fbRev), .stepFwdOut(stepFwd), .stepRevOut(stepRev), .driveEnableOut(driveEn),
        .loopEnableOut(loopEn), .faultOut(faultOut), .positionDoneOut(posDone), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (reset) begin
            fwdCnt <= 0;
            revCnt <= 0;
        end else begin
            fwdCnt <= fwdCnt + int'(stepFwd === 1'b1);
            revCnt <= revCnt + int'(stepRev === 1'b1);
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        @(posedge sys_clk);
        while (apbRsp.pready !== 1'b1) @(posedge sys_clk);
        q = apbRsp.prdata;
        slvErr = apbRsp.pslverr;
        apbReq <= '0;
    endtask
    task automatic send(input logic f);
        hostFwd <= f;
        hostGo <= 1'b1;
        tick(1);
        hostGo <= 1'b0;
        tick(1);
        for (int i = 0; i < 1000 && busy === 1'b1; i++) tick(1);
        tick(12);
    endtask
    task automatic testReset();
        check("alarm pwr", 32'(faultOut), 32'h0);
        apb(1'b0, ADDR_RANGE, 32'h0);
        check("range", q, 32'(RANGE_RESET));
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", {q[30:0], slvErr}, 32'h1);
        for (int i = 0; i < 1100 && faultOut !== 1'b1; i++) tick(1);
        check("alarm init", 32'(faultOut), 32'h1);
    endtask
    task automatic testModes();
        int f, r, e;
        for (int m = 0; m <= 9; m++) begin
            run <= 1'b0;
            tick(12);
            apb(1'b1, ADDR_CTRL, 32'(m));
            hostMode <= 4'(m);
            tick(12);
            run <= 1'b1;
            tick(12);
            check("drive", 32'(driveEn), 32'h1);
            {f, r} = {fwdCnt, revCnt};
            e = (m % 5 == 4) ? 4 : (m % 5 == 3) ? 2 : 1;
            send(1'b1);
            send(1'b0);
            check("fwd", 32'(fwdCnt - f), 32'(e));
            check("rev", 32'(revCnt - r), 32'(e));
        end
    endtask
    task automatic testJog();
        int f;
        run <= 1'b0;
        tick(12);
        f = fwdCnt;
        send(1'b1);
        check("refused", 32'(fwdCnt - f), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h10);
        hostMode <= 4'h0;
        tick(12);
        check("jog", 32'(fwdCnt - f), 32'h1);
    endtask
    task automatic testClear();
        run <= 1'b1;
        devClear <= 1'b1;
        tick(1000);
        devClear <= 1'b0;
        tick(12);
        apb(1'b0, ADDR_DEV, 32'h0);
        check("short clr", q, 32'h1);
        check("loop", 32'(loopEn), 32'h1);
        devClear <= 1'b1;
        tick(2012);
        send(1'b1);
        apb(1'b0, ADDR_DEV, 32'h0);
        check("dev clr", q, 32'h0);
        check("loop clr", 32'(loopEn), 32'h0);
        devClear <= 1'b0;
        tick(12);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        check("clr event", q & 32'h1, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        tick(1);
        check("irq on", 32'(irq), 32'h1);
        apb(1'b1, ADDR_INT_STAT, 32'h1);
        tick(1);
        check("irq off", 32'(irq), 32'h0);
    endtask
    task automatic testAlarm();
        faultDetect <= 1'b1;
        tick(1);
        faultDetect <= 1'b0;
        tick(3);
        check("alarm", 32'(faultOut), 32'h0);
        check("drive off", 32'(driveEn), 32'h0);
        run <= 1'b0;
        tick(12);
        alarmReset <= 1'b1;
        tick(12);
        alarmReset <= 1'b0;
        check("alarm rst", 32'(faultOut), 32'h1);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        check("alarm events", q & 32'h6, 32'h6);
    endtask
    task automatic testPosDone();
        int r;
        apb(1'b1, ADDR_RANGE, 32'h2);
        run <= 1'b1;
        tick(12);
        send(1'b1);
        send(1'b1);
        check("out of pos", 32'(posDone), 32'h0);
        fbFwd <= 1'b1;
        tick(1);
        fbFwd <= 1'b0;
        tick(3);
        check("in pos", 32'(posDone), 32'h1);
        r = revCnt;
        apb(1'b1, ADDR_CTRL, 32'h20);
        fbRev <= 1'b1;
        tick(1);
        fbRev <= 1'b0;
        tick(12);
        check("jog rev", 32'(revCnt - r), 32'h1);
        apb(1'b0, ADDR_DEV, 32'h0);
        check("dev fb", q, 32'h1);
    endtask
    task automatic finalReport();
        $display("checks %0d errors %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        errTotal++;
        finalReport();
    end
    initial begin
        reset = 1'b1;
        {hostGo, hostFwd, devClear, run, alarmReset, faultDetect, fbFwd, fbRev} = 8'h00;
        {hostMode, apbReq, errTotal, checked} = '0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        testReset();
        testModes();
        testJog();
        testClear();
        testAlarm();
        testPosDone();
        finalReport();
    end
endmodule // tb
`default_nettype wire
